// ### src/nvcs_regs.vh
// register offsets, field positions, reset values and list codes of the save/restore block
`ifndef NVCS_REGS_VH
`define NVCS_REGS_VH

// register offsets on the serial control port
`define NVCS_OFS_STATE      12'hB00
`define NVCS_OFS_ERROR      12'hB01
`define NVCS_OFS_RST_PROT   12'hB02
`define NVCS_OFS_SAVE       12'hB03
`define NVCS_OFS_SEG_LO     12'hA00
`define NVCS_OFS_SEG_HI     12'hAFF
`define NVCS_SEG_PAGE       4'hA

// field positions
`define NVCS_BIT_BUSY       0
`define NVCS_BIT_ERROR      0
`define NVCS_BIT_PROTECT    0
`define NVCS_BIT_SOFT_LOAD  1
`define NVCS_BIT_SAVE       0
`define NVCS_BIT_OPCODE     7

// reset values
`define NVCS_RST_PROTECT    1'b0
`define NVCS_RST_BYTE       8'h00

// operational codes of the buffer segment list and the index of the segment's last byte
`define NVCS_OP_COMMIT      8'h80
`define NVCS_OP_END         8'hFF
`define NVCS_SEG_LAST       8'hFF

// idle gap that software keeps between transfers
`define NVCS_GAP_US         10
`define NVCS_CLK_MHZ        125
`define NVCS_GAP_CYC        (`NVCS_GAP_US * `NVCS_CLK_MHZ)

`endif

// ### src/nvcs_seg_mem.v
// buffer segment store: one write port, one read port with registered data
`timescale 1ns/100ps
module nvcs_seg_mem
#(
   parameter AW = 8,
   parameter DW = 8
)
(
   input  wire          clk_i,
   input  wire          ce_i,
   input  wire          we_i,
   input  wire [AW-1:0] waddr_i,
   input  wire [DW-1:0] wdata_i,
   input  wire [AW-1:0] raddr_i,
   output reg  [DW-1:0] rdata_o
);

   reg [DW-1:0] mem_reg [0:(1<<AW)-1];

   // write and registered read, frozen while ce_i is low
   always @(posedge clk_i)
   begin
      if (ce_i)
      begin
         if (we_i)
            mem_reg[waddr_i] <= wdata_i;
         rdata_o <= mem_reg[raddr_i];
      end
   end

endmodule

// ### src/nvcs_top.v
// save/restore controller between the register buffer bank and the nonvolatile store
`timescale 1ns/100ps
`include "nvcs_regs.vh"
//////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - Busy flag at 0xB00 bit 0 reads 1 during save or load, else 0.
// - With status select set, the busy flag drives the status pin.
// - Error flag at 0xB01 bit 0 reads 1 after bad data in a transfer.
// - Boot pin low: writing 1 to 0xB02 bit 1 reloads stored settings; self-clears.
// - Write-enable bit 0xB02 bit 0 resets to 0, blocking all saves.
// - Write-enable bit at 1 allows software-started saves.
// - Writing 1 to 0xB03 bit 0 starts copying buffer registers to the store.
// - The save bit clears itself when the save has finished.
// - Command bit 7 low means data transfer of low seven bits plus one bytes.
// - Next two bytes hold the register start address, high byte first.
// - Commit code copies buffer registers to active ones, like writing 0x232.
// - Processing stops at end-of-data, which must come by the segment's last byte.
module nvcs_top
#(
   parameter NV_AW = 12
)
(
   input  wire             clk_i,
   input  wire             rst_n_i,
   input  wire             ce_i,
   // register access from the serial control port
   input  wire             wr_en_i,
   input  wire             rd_en_i,
   input  wire [11:0]      addr_i,
   input  wire [7:0]       wr_data_i,
   output wire [7:0]       rd_data_o,
   // pins and neighbouring control bits
   input  wire             nv_boot_sel_i,
   input  wire             status_sel_i,
   input  wire             status_alt_i,
   output wire             status_o,
   output reg              soft_reset_o,
   output reg              commit_o,
   // buffer register bank
   output reg  [15:0]      bank_addr_o,
   input  wire [7:0]       bank_rdata_i,
   output reg  [7:0]       bank_wdata_o,
   output reg              bank_we_o,
   // nonvolatile array
   output reg              nv_req_o,
   output reg              nv_we_o,
   output reg  [NV_AW-1:0] nv_addr_o,
   output reg  [7:0]       nv_wdata_o,
   input  wire             nv_ack_i,
   input  wire [7:0]       nv_rdata_i,
   input  wire             nv_err_i
);

   localparam [2:0] S_IDLE  = 3'd0;
   localparam [2:0] S_FETCH = 3'd1;
   localparam [2:0] S_TAKE  = 3'd2;
   localparam [2:0] S_MOVE  = 3'd3;
   localparam [2:0] S_NVWT  = 3'd4;
   localparam [2:0] S_BKWR  = 3'd5;

   localparam [1:0] P_CMD = 2'd0;
   localparam [1:0] P_AHI = 2'd1;
   localparam [1:0] P_ALO = 2'd2;

   reg  [2:0]       state_reg;
   reg  [1:0]       phase_reg;
   reg              busy_reg;
   reg              error_reg;
   reg              protect_off_reg;
   reg              soft_load_reg;
   reg              save_reg;
   reg              dir_save_reg;
   reg  [7:0]       seg_ptr_reg;
   reg  [6:0]       left_reg;
   reg  [7:0]       rd_q_reg;
   reg              seg_rd_reg;
   wire [7:0]       seg_rdata;
   wire             seg_hit;
   wire             start_save;
   wire             start_load;

   //////////////////////////////////////////////////////////////////////////////////////////
   // register decode

   // segment range written by host only while idle
   assign seg_hit    = (addr_i[11:8] == `NVCS_SEG_PAGE);
   assign start_save = wr_en_i && !busy_reg && (addr_i == `NVCS_OFS_SAVE)
                       && wr_data_i[`NVCS_BIT_SAVE] && protect_off_reg;
   assign start_load = wr_en_i && !busy_reg && (addr_i == `NVCS_OFS_RST_PROT)
                       && wr_data_i[`NVCS_BIT_SOFT_LOAD] && !nv_boot_sel_i;

   nvcs_seg_mem #(.AW(8), .DW(8)) u_seg
   (
      .clk_i   (clk_i),
      .ce_i    (ce_i),
      .we_i    (wr_en_i && seg_hit && !busy_reg),
      .waddr_i (addr_i[7:0]),
      .wdata_i (wr_data_i),
      .raddr_i (busy_reg ? seg_ptr_reg : addr_i[7:0]),
      .rdata_o (seg_rdata)
   );

   // read data: both sources are flops, answer one cycle after rd_en_i
   assign rd_data_o = seg_rd_reg ? seg_rdata : rd_q_reg;

   // busy flag mirrored on the status pin when selected
   assign status_o = status_sel_i ? busy_reg : status_alt_i;

   // register read capture
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rd_q_reg   <= `NVCS_RST_BYTE;
         seg_rd_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         seg_rd_reg <= rd_en_i && seg_hit && !busy_reg;
         if (!rd_en_i)
            rd_q_reg <= `NVCS_RST_BYTE;
         else if (addr_i == `NVCS_OFS_STATE)
            rd_q_reg <= {7'h00, busy_reg};
         else if (addr_i == `NVCS_OFS_ERROR)
            rd_q_reg <= {7'h00, error_reg};
         else if (addr_i == `NVCS_OFS_RST_PROT)
            rd_q_reg <= {6'h00, soft_load_reg, protect_off_reg};
         else if (addr_i == `NVCS_OFS_SAVE)
            rd_q_reg <= {7'h00, save_reg};
         else
            rd_q_reg <= `NVCS_RST_BYTE;
      end
   end

   // write-enable bit, plain read/write
   always @(posedge clk_i)
   begin
      if (!rst_n_i)
         protect_off_reg <= `NVCS_RST_PROTECT;
      else if (ce_i && wr_en_i && (addr_i == `NVCS_OFS_RST_PROT))
         protect_off_reg <= wr_data_i[`NVCS_BIT_PROTECT];
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // list walker

   always @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg     <= S_IDLE;
         phase_reg     <= P_CMD;
         busy_reg      <= 1'b0;
         error_reg     <= 1'b0;
         soft_load_reg <= 1'b0;
         save_reg      <= 1'b0;
         dir_save_reg  <= 1'b0;
         seg_ptr_reg   <= 8'h00;
         left_reg      <= 7'h00;
         soft_reset_o  <= 1'b0;
         commit_o      <= 1'b0;
         bank_addr_o   <= 16'h0000;
         bank_wdata_o  <= 8'h00;
         bank_we_o     <= 1'b0;
         nv_req_o      <= 1'b0;
         nv_we_o       <= 1'b0;
         nv_addr_o     <= {NV_AW{1'b0}};
         nv_wdata_o    <= 8'h00;
      end
      else if (ce_i)
      begin
         soft_reset_o <= 1'b0;
         commit_o     <= 1'b0;
         bank_we_o    <= 1'b0;
         case (state_reg)
            S_IDLE:
            begin
               if (start_save || start_load)
               begin
                  busy_reg      <= 1'b1;
                  error_reg     <= 1'b0;
                  save_reg      <= start_save;
                  soft_load_reg <= start_load;
                  soft_reset_o  <= start_load;
                  dir_save_reg  <= start_save;
                  seg_ptr_reg   <= 8'h00;
                  phase_reg     <= P_CMD;
                  nv_addr_o     <= {NV_AW{1'b0}};
                  state_reg     <= S_FETCH;
               end
            end
            S_FETCH:
               state_reg <= S_TAKE;
            S_TAKE:
            begin
               seg_ptr_reg <= seg_ptr_reg + 8'h01;
               state_reg   <= S_FETCH;
               if (phase_reg == P_CMD && seg_rdata == `NVCS_OP_END)
               begin
                  busy_reg      <= 1'b0;
                  save_reg      <= 1'b0;
                  soft_load_reg <= 1'b0;
                  state_reg     <= S_IDLE;
               end
               else if (seg_ptr_reg == `NVCS_SEG_LAST)
               begin
                  error_reg     <= 1'b1;
                  busy_reg      <= 1'b0;
                  save_reg      <= 1'b0;
                  soft_load_reg <= 1'b0;
                  state_reg     <= S_IDLE;
               end
               else if (phase_reg == P_CMD && seg_rdata == `NVCS_OP_COMMIT)
                  commit_o <= 1'b1;
               else if (phase_reg == P_CMD && !seg_rdata[`NVCS_BIT_OPCODE])
               begin
                  left_reg  <= seg_rdata[6:0];
                  phase_reg <= P_AHI;
               end
               else if (phase_reg == P_AHI)
               begin
                  bank_addr_o[15:8] <= seg_rdata;
                  phase_reg         <= P_ALO;
               end
               else if (phase_reg == P_ALO)
               begin
                  bank_addr_o[7:0] <= seg_rdata;
                  phase_reg        <= P_CMD;
                  state_reg        <= S_MOVE;
               end
            end
            S_MOVE:
            begin
               nv_req_o   <= 1'b1;
               nv_we_o    <= dir_save_reg;
               nv_wdata_o <= bank_rdata_i;
               state_reg  <= S_NVWT;
            end
            S_NVWT:
            begin
               if (nv_ack_i)
               begin
                  nv_req_o  <= 1'b0;
                  nv_addr_o <= nv_addr_o + {{(NV_AW-1){1'b0}}, 1'b1};
                  if (nv_err_i)
                  begin
                     error_reg     <= 1'b1;
                     busy_reg      <= 1'b0;
                     save_reg      <= 1'b0;
                     soft_load_reg <= 1'b0;
                     state_reg     <= S_IDLE;
                  end
                  else if (!dir_save_reg)
                  begin
                     bank_wdata_o <= nv_rdata_i;
                     bank_we_o    <= 1'b1;
                     state_reg    <= S_BKWR;
                  end
                  else
                     state_reg <= S_BKWR;
               end
            end
            S_BKWR:
            begin
               // next byte of the run, or back to the list
               bank_addr_o <= bank_addr_o + 16'h0001;
               left_reg    <= left_reg - 7'h01;
               state_reg   <= (left_reg == 7'h00) ? S_FETCH : S_MOVE;
            end
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end

endmodule

// ### verif/nv_config_save_restore_tb.sv
// self-checking bench for the save/restore controller
`timescale 1ns/100ps
`include "nvcs_regs.vh"
module nv_config_save_restore_tb;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        ce_i = 1'b1;
   logic        wr_en_i = 1'b0;
   logic        rd_en_i = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [7:0]  wr_data_i = 8'h00;
   logic        nv_boot_sel_i = 1'b1;
   logic        status_sel_i = 1'b1;
   logic        status_alt_i = 1'b0;
   logic [3:0]  dly = 4'h3;
   logic        bad = 1'b0;
   wire  [7:0]  rd_data_o, bank_rdata_i, bank_wdata_o, nv_wdata_o, nv_rdata_i;
   wire  [15:0] bank_addr_o;
   wire  [11:0] nv_addr_o;
   wire         status_o, soft_reset_o, commit_o, bank_we_o, nv_req_o, nv_we_o;
   wire         nv_ack_i, nv_err_i;
   int          errors = 0;
   int          n_tests = 0;
   int          acks = 0;
   int          commits = 0;
   int          softs = 0;
   logic [7:0]  list [5] = '{8'h01, 8'h12, 8'h34, `NVCS_OP_COMMIT, `NVCS_OP_END};
   nvcs_top dut_u (.*);
   nvcs_nv_model nv_u (.clk_i(clk_i), .req_i(nv_req_o), .we_i(nv_we_o), .addr_i(nv_addr_o),
      .wdata_i(nv_wdata_o), .bank_addr_i(bank_addr_o), .bank_wdata_i(bank_wdata_o),
      .bank_we_i(bank_we_o), .dly_i(dly), .bad_i(bad), .ack_o(nv_ack_i),
      .rdata_o(nv_rdata_i), .err_o(nv_err_i), .bank_rdata_o(bank_rdata_i));
   //////////////////////////////////////////////////////////////////////////////////////
   // clock
   initial
   begin
      forever #4 clk_i = ~clk_i;
   end
   // tally acknowledges, commits and soft loads
   always @(posedge clk_i)
   begin
      if (nv_req_o && nv_ack_i)
         acks <= acks + 1;
      if (commit_o)
         commits <= commits + 1;
      if (soft_reset_o)
         softs <= softs + 1;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk_i);
      {wr_en_i, addr_i, wr_data_i} = {1'b1, a, d};
      @(negedge clk_i);
      wr_en_i = 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      @(negedge clk_i);
      {rd_en_i, addr_i} = {1'b1, a};
      @(negedge clk_i);
      rd_en_i = 1'b0;
      chk(rd_data_o, e);
   endtask
   // wait for busy to drop under a bound, then keep the idle gap
   task automatic idle;
      int i;
      for (i = 0; i < 400 && status_o !== 1'b0; i++)
         @(negedge clk_i);
      chk(status_o, 1'b0);
      repeat (`NVCS_GAP_CYC) @(negedge clk_i);
   endtask
   task automatic give_verdict;
      $display("checks %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////////////
   // scenarios
   initial
   begin
      repeat (16) @(negedge clk_i);
      rst_n_i = 1'b1;
      rdc(12'hB00, 8'h00);
      rdc(12'hB01, 8'h00);
      rdc(12'hB02, 8'h00);
      rdc(12'hB04, 8'h00);
      foreach (list[i]) wr(12'hA00 + 12'(i), list[i]);
      rdc(12'hA01, 8'h12);
      nv_u.bank[16'h1234] = 8'h5A;
      nv_u.bank[16'h1235] = 8'hC3;
      wr(12'hB03, 8'h01);
      rdc(12'hB00, 8'h00);
      chk(acks, 0);
      wr(12'hB02, 8'h01);
      rdc(12'hB02, 8'h01);
      // a write while the clock enable is low must leave the write-enable bit alone
      @(negedge clk_i);
      ce_i = 1'b0;
      wr(12'hB02, 8'h00);
      ce_i = 1'b1;
      rdc(12'hB02, 8'h01);
      wr(12'hB03, 8'h01);
      rdc(12'hB00, 8'h01);
      rdc(12'hB03, 8'h01);
      idle;
      rdc(12'hB03, 8'h00);
      rdc(12'hB00, 8'h00);
      chk({nv_u.mem[0], nv_u.mem[1]}, 16'h5AC3);
      chk(acks, 2);
      chk(commits, 1);
      nv_u.bank[16'h1234] = 8'h00;
      nv_u.bank[16'h1235] = 8'h00;
      wr(12'hB02, 8'h03);
      rdc(12'hB00, 8'h00);
      nv_boot_sel_i = 1'b0;
      dly = 4'h0;
      wr(12'hB02, 8'h03);
      idle;
      chk(softs, 1);
      chk({nv_u.bank[16'h1234], nv_u.bank[16'h1235]}, 16'h5AC3);
      rdc(12'hB02, 8'h01);
      chk(commits, 2);
      bad = 1'b1;
      dly = 4'h9;
      wr(12'hB03, 8'h01);
      idle;
      bad = 1'b0;
      rdc(12'hB01, 8'h01);
      rdc(12'hB03, 8'h00);
      chk(acks, 5);
      status_sel_i = 1'b0;
      status_alt_i = 1'b1;
      @(negedge clk_i);
      chk(status_o, 1'b1);
      give_verdict;
   end
   // watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge clk_i);
      errors++;
      give_verdict;
   end
endmodule

// ### verif/nvcs_nv_model.sv
// behavioural nonvolatile array and buffer register bank
`timescale 1ns/100ps
module nvcs_nv_model
(
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [11:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic [15:0] bank_addr_i,
   input  wire logic [7:0]  bank_wdata_i,
   input  wire logic        bank_we_i,
   input  wire logic [3:0]  dly_i,
   input  wire logic        bad_i,
   output logic             ack_o = 1'b0,
   output logic [7:0]       rdata_o = 8'h00,
   output logic             err_o = 1'b0,
   output wire logic [7:0]  bank_rdata_o
);
   logic [7:0] mem [0:4095];
   logic [7:0] bank [0:65535];
   int         cnt = 0;
   // bank read data follows the address at once
   assign bank_rdata_o = bank[bank_addr_i];
   // one acknowledge after dly_i waits; released read data toggles
   always @(posedge clk_i)
   begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (bank_we_i)
         bank[bank_addr_i] <= bank_wdata_i;
      if (req_i && !ack_o && cnt == dly_i)
      begin
         ack_o <= 1'b1;
         err_o <= bad_i;
         rdata_o <= mem[addr_i];
         if (we_i)
            mem[addr_i] <= wdata_i;
         cnt <= 0;
      end
      else if (req_i && !ack_o)
         cnt <= cnt + 1;
   end
endmodule

// ### verif/nvcs_props.sv
// port checker for the save/restore controller
`timescale 1ns/100ps
module nvcs_props
#(
   parameter NV_AW = 12
)
(
   input wire logic             clk_i,
   input wire logic             rst_n_i,
   input wire logic             rd_en_i,
   input wire logic [7:0]       rd_data_o,
   input wire logic             status_sel_i,
   input wire logic             status_alt_i,
   input wire logic             status_o,
   input wire logic             soft_reset_o,
   input wire logic             commit_o,
   input wire logic [7:0]       bank_rdata_i,
   input wire logic [7:0]       bank_wdata_o,
   input wire logic             bank_we_o,
   input wire logic             nv_req_o,
   input wire logic             nv_we_o,
   input wire logic [NV_AW-1:0] nv_addr_o,
   input wire logic [7:0]       nv_wdata_o,
   input wire logic             nv_ack_i,
   input wire logic [7:0]       nv_rdata_i,
   input wire logic             nv_err_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [7:0] took_q;
   // store data held from the latest acknowledge
   always_ff @(posedge clk_i)
      if (nv_ack_i)
         took_q <= nv_rdata_i;
   sequence s_ack; nv_req_o && nv_ack_i; endsequence
   sequence s_fail; s_ack ##0 nv_err_i; endsequence
   status_busy_a: assert property (status_sel_i && nv_req_o |-> status_o)
      else $error("status pin low during store access");
   status_alt_a: assert property (!status_sel_i |-> status_o == status_alt_i)
      else $error("status pin ignores alternate source");
   req_hold_a: assert property (nv_req_o && !nv_ack_i |=> nv_req_o && $stable(nv_addr_o))
      else $error("store request dropped or moved before acknowledge");
   req_drop_a: assert property (s_ack |=> !nv_req_o)
      else $error("store request held after acknowledge");
   save_data_a: assert property (nv_req_o && nv_we_o |-> nv_wdata_o == bank_rdata_i)
      else $error("saved byte differs from bank byte");
   load_write_a: assert property (s_ack ##0 !nv_we_o && !nv_err_i
      |-> ##[1:2] bank_we_o && bank_wdata_o == took_q)
      else $error("loaded byte not written to bank");
   soft_pulse_a: assert property (soft_reset_o |=> !soft_reset_o)
      else $error("soft reset pulse too long");
   commit_pulse_a: assert property (commit_o |=> !commit_o)
      else $error("commit pulse too long");
   rd_idle_a: assert property (!rd_en_i |=> rd_data_o == 8'h00)
      else $error("read data without a read");
   err_quiet_a: assert property (s_fail |=> !nv_req_o [*8])
      else $error("store access after error abort");
endmodule
bind nvcs_top nvcs_props #(.NV_AW(NV_AW)) props_u (.*);
